/* File: design/lcs_sequencer.v */
// Conversion sequencer of an ambient light sensing front end.
// Assumes a serial interface on clk_sys supplies configuration writes
// and a read-busy level; light pulses and bus pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "lcs_defs.vh"

// Functional notes
// - Integration lasts 400, 200 or 100 ms for select codes 00, 01 and 10.
// - Each integration length is a whole multiple of 50 ms.
// - Continuous mode without skip adds 60, 30 or 15 ms of low power, giving 460, 230 or 115 ms cycles.
// - With power-save skip set the cycle lasts one integration plus the one-clock transfer.
// - A finished conversion moves its result into the readable output registers.
// - The result is double-buffered so a read in progress never sees a mixed value.
// - After each transfer the mode and skip bit decide between a new integration, the low-power interval and power-down.
// - Single-cycle mode runs one acquisition and then powers down by itself.
// - Continuous mode repeats forever and only it uses the low-power interval.
// - The result is an unsigned 16-bit count that saturates at 65535.
// - Clock or data held low for 25 to 35 ms is a bus timeout.
// - Mode 00 is power-down, 01 reserved, 10 single acquisition, 11 continuous.
// - The result is read as separate low and high byte registers.
module lcs_sequencer #(
  parameter integer P_TICK_CYC = `LCS_TICK_CYC,
  parameter integer P_TMO_CYC  = `LCS_TMO_CYC
) (
  input  wire       clk_sys,
  input  wire       arst_n,
  input  wire       cfg_wr,
  input  wire [1:0] mode_wr_val,
  input  wire [1:0] itime_wr_val,
  input  wire       pskip_wr_val,
  input  wire       read_busy,
  input  wire       light_pulse,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg  [1:0] op_mode_ff,
  output reg  [1:0] integration_time_select_ff,
  output reg        power_save_skip_ff,
  output reg  [7:0] result_low_byte_ff,
  output reg  [7:0] result_high_byte_ff,
  output reg        result_new_ff,
  output reg        integrating_ff,
  output wire       bus_abort_ff
);

  // ****************************************************************
  // States and helpers
  // ****************************************************************
  localparam [1:0] ST_PDOWN = 2'h0;
  localparam [1:0] ST_INTEG = 2'h1;
  localparam [1:0] ST_XFER  = 2'h2;
  localparam [1:0] ST_PSAVE = 2'h3;

  // Lengths in 5 ms ticks
  function [6:0] tint_ticks;
    input [1:0] sel;
    integer     t;
    begin
      case (sel)
        `LCS_ITIME_200: t = `LCS_TINT_200_MS / `LCS_TICK_MS;
        `LCS_ITIME_100: t = `LCS_TINT_100_MS / `LCS_TICK_MS;
        default:        t = `LCS_TINT_400_MS / `LCS_TICK_MS;
      endcase
      tint_ticks = t[6:0];
    end
  endfunction

  function [6:0] psave_ticks;
    input [1:0] sel;
    integer     t;
    begin
      case (sel)
        `LCS_ITIME_200: t = `LCS_PSAVE_200_MS / `LCS_TICK_MS;
        `LCS_ITIME_100: t = `LCS_PSAVE_100_MS / `LCS_TICK_MS;
        default:        t = `LCS_PSAVE_400_MS / `LCS_TICK_MS;
      endcase
      psave_ticks = t[6:0];
    end
  endfunction

  // ****************************************************************
  // Reset release
  // ****************************************************************
  reg [1:0] rst_sync_ff;
  wire      rst_n;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  // ****************************************************************
  // Light pulse synchroniser and edge detect
  // ****************************************************************
  reg [2:0] pulse_sync_ff;
  wire      pulse_rise;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pulse_sync_ff <= 3'h0;
    end else begin
      pulse_sync_ff <= {pulse_sync_ff[1:0], light_pulse};
    end
  end

  assign pulse_rise = pulse_sync_ff[1] & ~pulse_sync_ff[2];

  // ****************************************************************
  // Configuration
  // ****************************************************************
  reg  [1:0] state_ff;
  reg  [1:0] nxt_state;
  reg  [1:0] nxt_op_mode;
  reg  [1:0] run_sel_ff;
  reg  [6:0] tick_cnt_ff;
  reg  [6:0] nxt_tick_cnt;
  reg [19:0] cyc_cnt_ff;
  reg [15:0] acc_ff;
  reg [15:0] shadow_ff;
  reg        pending_ff;
  reg        nxt_pending;
  wire       tick;
  wire       run_mode;
  wire       start_req;
  wire [1:0] sel_src;

  // Reserved mode code behaves as power-down
  assign run_mode  = (op_mode_ff == `LCS_MODE_SINGLE) | (op_mode_ff == `LCS_MODE_CONT);
  assign start_req = cfg_wr & ((mode_wr_val == `LCS_MODE_SINGLE) | (mode_wr_val == `LCS_MODE_CONT));
  assign tick      = (cyc_cnt_ff == P_TICK_CYC[19:0] - 20'h00001);
  // A start strobe brings its own select with it
  assign sel_src   = cfg_wr ? itime_wr_val : integration_time_select_ff;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      integration_time_select_ff <= `LCS_ITIME_RST;
      power_save_skip_ff         <= `LCS_PSKIP_RST;
    end else if (cfg_wr) begin
      integration_time_select_ff <= itime_wr_val;
      power_save_skip_ff         <= pskip_wr_val;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always @* begin
    nxt_state    = state_ff;
    nxt_op_mode  = op_mode_ff;
    nxt_tick_cnt = tick_cnt_ff;
    if (cfg_wr) begin
      nxt_op_mode = mode_wr_val;
    end
    case (state_ff)
      ST_PDOWN: begin
        nxt_tick_cnt = 7'h00;
        if (start_req) begin
          nxt_state = ST_INTEG;
        end
      end
      ST_INTEG: begin
        if (!run_mode) begin
          nxt_state    = ST_PDOWN;
          nxt_tick_cnt = 7'h00;
        end else if (tick) begin
          if (tick_cnt_ff == tint_ticks(run_sel_ff) - 7'h01) begin
            nxt_state    = ST_XFER;
            nxt_tick_cnt = 7'h00;
          end else begin
            nxt_tick_cnt = tick_cnt_ff + 7'h01;
          end
        end
      end
      ST_XFER: begin
        nxt_tick_cnt = 7'h00;
        if (op_mode_ff == `LCS_MODE_CONT && !cfg_wr) begin
          if (power_save_skip_ff) begin
            nxt_state = ST_INTEG;
          end else begin
            nxt_state = ST_PSAVE;
          end
        end else if (cfg_wr && start_req) begin
          nxt_state = ST_INTEG;
        end else begin
          nxt_state = ST_PDOWN;
          if (!cfg_wr) begin
            nxt_op_mode = `LCS_MODE_PDOWN;
          end
        end
      end
      ST_PSAVE: begin
        if (op_mode_ff != `LCS_MODE_CONT) begin
          nxt_state    = ST_PDOWN;
          nxt_tick_cnt = 7'h00;
        end else if (tick) begin
          if (tick_cnt_ff == psave_ticks(run_sel_ff) - 7'h01) begin
            nxt_state    = ST_INTEG;
            nxt_tick_cnt = 7'h00;
          end else begin
            nxt_tick_cnt = tick_cnt_ff + 7'h01;
          end
        end
      end
      default: begin
        nxt_state    = ST_PDOWN;
        nxt_tick_cnt = 7'h00;
      end
    endcase
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff       <= ST_PDOWN;
      op_mode_ff     <= `LCS_MODE_RST;
      tick_cnt_ff    <= 7'h00;
      cyc_cnt_ff     <= 20'h00000;
      run_sel_ff     <= `LCS_ITIME_RST;
      integrating_ff <= 1'b0;
    end else begin
      state_ff       <= nxt_state;
      op_mode_ff     <= nxt_op_mode;
      tick_cnt_ff    <= nxt_tick_cnt;
      integrating_ff <= (nxt_state == ST_INTEG);
      // Timebase restarts on every state change and halts in power-down
      if (nxt_state != state_ff || nxt_state == ST_PDOWN || tick) begin
        cyc_cnt_ff <= 20'h00000;
      end else begin
        cyc_cnt_ff <= cyc_cnt_ff + 20'h00001;
      end
      // Integration length is fixed for the whole acquisition
      if (nxt_state == ST_INTEG && state_ff != ST_INTEG) begin
        run_sel_ff <= (sel_src == 2'h3) ? `LCS_ITIME_100 : sel_src;
      end
    end
  end

  // ****************************************************************
  // Count accumulation and double-buffered result
  // ****************************************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= `LCS_RESULT_RST;
    end else if (state_ff != ST_INTEG) begin
      acc_ff <= `LCS_RESULT_RST;
    end else if (pulse_rise && acc_ff != `LCS_RESULT_MAX) begin
      acc_ff <= acc_ff + 16'h0001;
    end
  end

  always @* begin
    nxt_pending = pending_ff;
    if (!read_busy) begin
      nxt_pending = 1'b0;
    end
    if (state_ff == ST_XFER) begin
      nxt_pending = 1'b1;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shadow_ff           <= `LCS_RESULT_RST;
      pending_ff          <= 1'b0;
      result_low_byte_ff  <= 8'h00;
      result_high_byte_ff <= 8'h00;
      result_new_ff       <= 1'b0;
    end else begin
      pending_ff    <= nxt_pending;
      result_new_ff <= 1'b0;
      if (state_ff == ST_XFER) begin
        shadow_ff <= acc_ff;
      end
      // Output pair changes only while no read is in progress
      if (pending_ff && !read_busy) begin
        result_low_byte_ff  <= shadow_ff[7:0];
        result_high_byte_ff <= shadow_ff[15:8];
        result_new_ff       <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Bus timeout
  // ****************************************************************
  lcs_bus_timeout #(
    .P_TMO_CYC (P_TMO_CYC)
  ) u_tmo (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .scl_in       (scl_in),
    .sda_in       (sda_in),
    .bus_abort_ff (bus_abort_ff)
  );

endmodule
`default_nettype wire

/* File: design/lcs_defs.vh */
// Constants of the light sensor conversion sequencer.
// Assumes a 20 MHz system clock; included by the design files and by the test checker and bench.
`ifndef LCS_DEFS_VH
`define LCS_DEFS_VH

// ****************************************************************
// Timebase
// ****************************************************************
`define LCS_CLK_KHZ        20000
`define LCS_TICK_MS        5
`define LCS_TICK_CYC       (`LCS_TICK_MS * `LCS_CLK_KHZ)
`define LCS_RIPPLE_MS      50
`define LCS_TMO_MIN_MS     25
`define LCS_TMO_MAX_MS     35
`define LCS_TMO_CYC        (`LCS_TMO_MIN_MS * `LCS_CLK_KHZ)

// ****************************************************************
// Integration and power-save lengths in milliseconds
// ****************************************************************
`define LCS_TINT_400_MS    400
`define LCS_TINT_200_MS    200
`define LCS_TINT_100_MS    100
`define LCS_PSAVE_400_MS   60
`define LCS_PSAVE_200_MS   30
`define LCS_PSAVE_100_MS   15

// ****************************************************************
// Field codes and reset values
// ****************************************************************
`define LCS_ITIME_400      2'h0
`define LCS_ITIME_200      2'h1
`define LCS_ITIME_100      2'h2
`define LCS_MODE_PDOWN     2'h0
`define LCS_MODE_RSVD      2'h1
`define LCS_MODE_SINGLE    2'h2
`define LCS_MODE_CONT      2'h3
`define LCS_MODE_RST       2'h0
`define LCS_ITIME_RST      2'h0
`define LCS_PSKIP_RST      1'h0
`define LCS_RESULT_RST     16'h0000
`define LCS_RESULT_MAX     16'hFFFF

`endif

/* File: design/lcs_bus_timeout.v */
// Bus-timeout watch for the serial clock and data lines.
// Assumes both lines arrive unsynchronised from pins.
`timescale 1ns/1ps
`default_nettype none
`include "lcs_defs.vh"

module lcs_bus_timeout #(
  parameter integer P_TMO_CYC = `LCS_TMO_CYC
) (
  input  wire clk_sys,
  input  wire rst_n,
  input  wire scl_in,
  input  wire sda_in,
  output reg  bus_abort_ff
);

  // ****************************************************************
  // Synchronisers
  // ****************************************************************
  reg [1:0]  scl_sync_ff;
  reg [1:0]  sda_sync_ff;
  reg [19:0] low_cnt_ff;
  reg        fired_ff;
  wire       line_low;

  assign line_low = ~scl_sync_ff[1] | ~sda_sync_ff[1];

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
    end
  end

  // ****************************************************************
  // Low-time counter, one abort pulse per low episode
  // ****************************************************************
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_ff   <= 20'h00000;
      fired_ff     <= 1'b0;
      bus_abort_ff <= 1'b0;
    end else begin
      bus_abort_ff <= 1'b0;
      if (!line_low) begin
        low_cnt_ff <= 20'h00000;
        fired_ff   <= 1'b0;
      end else if (!fired_ff) begin
        if (low_cnt_ff == P_TMO_CYC[19:0] - 20'h00001) begin
          fired_ff     <= 1'b1;
          bus_abort_ff <= 1'b1;
        end else begin
          low_cnt_ff <= low_cnt_ff + 20'h00001;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: test/lcs_host_model.sv */
// Host model on the serial side of the sequencer.
// Assumes pull-ups on both lines; frames start on a rising frame_go.
`timescale 1ns/1ps
`default_nettype none
// ****
// Host model
// ****
module lcs_host_model (
  input  wire logic        frame_go,
  input  wire logic        hold_scl_low,
  input  wire logic        hold_sda_low,
  input  wire logic [1:0]  itime,
  input  wire logic [7:0]  lo,
  input  wire logic [7:0]  hi,
  output wire logic        scl,
  output wire logic        sda,
  output wire logic [17:0] lux
);
  logic scl_f;
  logic sda_f;
  initial begin
    scl_f = 1'b1;
    sda_f = 1'b1;
  end
  // Link clock of 400 ns runs only inside a frame
  always @(posedge frame_go) begin
    repeat (16) begin
      #200 scl_f = 1'b0;
      sda_f = ~sda_f;
      #200 scl_f = 1'b1;
    end
    sda_f = 1'b1;
  end
  assign scl = scl_f & ~hold_scl_low;
  assign sda = sda_f & ~hold_sda_low;
  // Count scaled by 1, 2, 4 or 8 from the current select
  assign lux = {2'h0, hi, lo} << itime;
endmodule
`default_nettype wire

/* File: test/lcs_sequencer_monitor.sv */
// Assertion checker of the light sensor conversion sequencer.
// Assumes it is bound to the sequencer top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "lcs_defs.vh"
// ****
// Checker
// ****
module lcs_sequencer_monitor #(
  parameter integer P_TICK_CYC = `LCS_TICK_CYC,
  parameter integer P_TMO_CYC  = `LCS_TMO_CYC
) (
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire logic       cfg_wr,
  input wire logic       read_busy,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic [1:0] op_mode_ff,
  input wire logic [1:0] integration_time_select_ff,
  input wire logic       power_save_skip_ff,
  input wire logic [7:0] result_low_byte_ff,
  input wire logic [7:0] result_high_byte_ff,
  input wire logic       result_new_ff,
  input wire logic       integrating_ff,
  input wire logic       bus_abort_ff
);
  logic [23:0] hi_cnt_ff;
  logic [19:0] low_cnt_ff;
  logic [1:0]  sel_ff;
  logic        abt_ff;
  logic        integ_q_ff;
  int          exp_len;
  assign exp_len = (sel_ff == 2'h0 ? `LCS_TINT_400_MS : sel_ff == 2'h1 ? `LCS_TINT_200_MS : `LCS_TINT_100_MS)
                   / `LCS_TICK_MS * P_TICK_CYC;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hi_cnt_ff <= 24'h000000;
      low_cnt_ff <= 20'h00000;
      sel_ff <= 2'h0;
      abt_ff <= 1'b0;
      integ_q_ff <= 1'b0;
    end else begin
      hi_cnt_ff <= integrating_ff ? hi_cnt_ff + 24'h000001 : 24'h000000;
      low_cnt_ff <= (scl_in && sda_in) ? 20'h00000 : low_cnt_ff + 20'h00001;
      integ_q_ff <= integrating_ff;
      if (integrating_ff && !integ_q_ff) begin
        sel_ff <= integration_time_select_ff;
      end
      if (!integrating_ff) begin
        abt_ff <= 1'b0;
      end else if (cfg_wr) begin
        abt_ff <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_integ_end;
    $fell(integrating_ff) && !abt_ff;
  endsequence
  AST_INTEG_LEN: assert property (s_integ_end |-> hi_cnt_ff == exp_len)
    else $error("integration length wrong");
  AST_RIPPLE_MULT: assert property (s_integ_end |-> hi_cnt_ff % (10 * P_TICK_CYC) == 0)
    else $error("integration not a multiple of 50 ms");
  AST_RESULT_MOVE: assert property (s_integ_end ##0 !read_busy |-> ##[1:3] result_new_ff)
    else $error("result not transferred");
  AST_BYTES_PAIRED: assert property ($changed({result_high_byte_ff, result_low_byte_ff}) |-> result_new_ff)
    else $error("result bytes changed without update");
  AST_BUSY_HOLDS: assert property (read_busy && $past(read_busy) |-> !result_new_ff)
    else $error("result updated during read");
  AST_SINGLE_DOWN: assert property (s_integ_end ##0 op_mode_ff == 2'h2 |-> ##[1:4] op_mode_ff == 2'h0)
    else $error("single mode did not power down");
  AST_PDOWN_HALT: assert property (
    !op_mode_ff[1] && !$past(op_mode_ff[1]) && !$past(op_mode_ff[1], 2) |-> !integrating_ff)
    else $error("integrating in power-down");
  AST_SKIP_RESTART: assert property (
    s_integ_end ##0 op_mode_ff == 2'h3 && power_save_skip_ff |-> ##[1:3] integrating_ff)
    else $error("no restart with skip");
  AST_PSAVE_GAP: assert property (
    s_integ_end ##0 op_mode_ff == 2'h3 && !power_save_skip_ff |-> (!integrating_ff) [*8])
    else $error("low-power interval missing");
  AST_ABORT_TIME: assert property (
    bus_abort_ff |-> low_cnt_ff >= P_TMO_CYC - 1 && low_cnt_ff <= P_TMO_CYC * 7 / 5)
    else $error("bus abort out of window");
  AST_ABORT_ONCE: assert property (bus_abort_ff |=> (!bus_abort_ff) [*8])
    else $error("bus abort repeated");
endmodule
`default_nettype wire

/* File: test/lcs_sequencer_tb_top.sv */
// Testbench of the light sensor conversion sequencer.
// Assumes the design, the host model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "lcs_defs.vh"
// ****
// Bench top
// ****
module lcs_sequencer_tb_top;
  localparam integer P_TICK = 10;
  localparam integer P_TMO  = 50;
  logic        clk_sys, arst_n, cfg_wr, pskip, read_busy, light_pulse, frame_go, hold_scl, hold_sda;
  logic [1:0]  mode_v, itime_v;
  wire         scl, sda, pskip_q, rnew, integ, abort;
  wire  [1:0]  op_mode, itime_q;
  wire  [7:0]  lo, hi;
  wire  [17:0] lux;
  int          err_total, comparisons;
  lcs_sequencer #(.P_TICK_CYC(P_TICK), .P_TMO_CYC(P_TMO)) i_lcs_sequencer (
    .clk_sys(clk_sys), .arst_n(arst_n), .cfg_wr(cfg_wr), .mode_wr_val(mode_v), .itime_wr_val(itime_v),
    .pskip_wr_val(pskip), .read_busy(read_busy), .light_pulse(light_pulse), .scl_in(scl), .sda_in(sda),
    .op_mode_ff(op_mode), .integration_time_select_ff(itime_q), .power_save_skip_ff(pskip_q),
    .result_low_byte_ff(lo), .result_high_byte_ff(hi), .result_new_ff(rnew), .integrating_ff(integ),
    .bus_abort_ff(abort));
  lcs_host_model i_lcs_host_model (.frame_go(frame_go), .hold_scl_low(hold_scl), .hold_sda_low(hold_sda),
    .itime(itime_q), .lo(lo), .hi(hi), .scl(scl), .sda(sda), .lux(lux));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic bound_hit;
    err_total++;
    $display("MISMATCH t=%0t wait bound used up", $time);
    summarize();
  endtask
  task automatic wait_lvl(input int w, input logic lvl, input int bound);
    int n;
    n = 0;
    while ((w == 0 ? integ : rnew) !== lvl) begin
      step(1);
      n++;
      if (n > bound) bound_hit();
    end
  endtask
  task automatic count_lvl(input logic lvl, output int n);
    n = 0;
    while (integ === lvl) begin
      step(1);
      n++;
      if (n > 2000) bound_hit();
    end
  endtask
  task automatic cfg(input logic [1:0] m, input logic [1:0] t, input logic s);
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    mode_v <= m;
    itime_v <= t;
    pskip <= s;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    #1;
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      light_pulse <= 1'b1;
      repeat (2) @(posedge clk_sys);
      light_pulse <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  function automatic int tint(input int c);
    return (c == 0 ? `LCS_TINT_400_MS : c == 1 ? `LCS_TINT_200_MS : `LCS_TINT_100_MS) / `LCS_TICK_MS;
  endfunction
  task automatic sc_single;
    int len;
    for (int c = 0; c < 3; c++) begin
      cfg(`LCS_MODE_SINGLE, c[1:0], 1'b1);
      wait_lvl(0, 1'b1, 10);
      fork pulses(c + 5); join_none
      count_lvl(1'b1, len);
      check(20'(len), 20'(tint(c) * P_TICK));
      check(20'(len % (`LCS_RIPPLE_MS / `LCS_TICK_MS * P_TICK)), 20'h0);
      wait_lvl(1, 1'b1, 5);
      check({4'h0, hi, lo}, 20'(c + 5));
      check({2'h0, lux}, 20'((c + 5) << c));
      step(60);
      check({1'b0, op_mode, integ, hi, lo}, 20'(c + 5));
    end
  endtask
  task automatic sc_cont;
    int len, gap, exp;
    for (int s = 0; s < 2; s++) begin
      cfg(`LCS_MODE_PDOWN, `LCS_ITIME_400, 1'b0);
      step(3);
      cfg(`LCS_MODE_CONT, `LCS_ITIME_100, s[0]);
      check(20'(pskip_q), 20'(s));
      wait_lvl(0, 1'b1, 10);
      count_lvl(1'b1, len);
      count_lvl(1'b0, gap);
      exp = (`LCS_TINT_100_MS + (s == 1 ? 0 : `LCS_PSAVE_100_MS)) / `LCS_TICK_MS * P_TICK;
      check(20'(len + gap >= exp && len + gap <= exp + 4), 20'h1);
    end
  endtask
  task automatic sc_busy;
    logic [15:0] old;
    int len;
    step(4);
    old = {hi, lo};
    @(posedge clk_sys);
    read_busy <= 1'b1;
    fork pulses(3); join_none
    count_lvl(1'b1, len);
    step(10);
    check({4'h0, hi, lo}, {4'h0, old});
    @(posedge clk_sys);
    read_busy <= 1'b0;
    wait_lvl(1, 1'b1, 5);
    check({4'h0, hi, lo}, 20'h3);
    cfg(`LCS_MODE_RSVD, `LCS_ITIME_100, 1'b1);
    step(300);
    check({3'h0, integ, hi, lo}, 20'h3);
  endtask
  task automatic watch(input int cyc, output int cnt, output int first);
    cnt = 0;
    first = -1;
    for (int i = 0; i < cyc; i++) begin
      step(1);
      if (abort === 1'b1) begin
        if (first < 0) first = i;
        cnt++;
      end
    end
  endtask
  task automatic sc_bus;
    int cnt, first;
    @(posedge clk_sys);
    frame_go <= 1'b1;
    watch(150, cnt, first);
    check(20'(cnt), 20'h0);
    for (int l = 0; l < 2; l++) begin
      @(posedge clk_sys);
      frame_go <= 1'b0;
      hold_scl <= 1'b0;
      hold_sda <= 1'b0;
      step(4);
      @(posedge clk_sys);
      hold_scl <= (l == 0);
      hold_sda <= (l == 1);
      watch(100, cnt, first);
      check(20'(cnt), 20'h1);
      check(20'(first >= P_TMO - 2 && first <= P_TMO * 7 / 5), 20'h1);
    end
    @(posedge clk_sys);
    hold_sda <= 1'b0;
  endtask
  initial begin
    err_total = 0;
    comparisons = 0;
    arst_n = 1'b0;
    cfg_wr = 1'b0;
    mode_v = 2'h0;
    itime_v = 2'h0;
    pskip = 1'b0;
    read_busy = 1'b0;
    light_pulse = 1'b0;
    frame_go = 1'b0;
    hold_scl = 1'b0;
    hold_sda = 1'b0;
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    step(4);
    sc_single();
    sc_cont();
    sc_busy();
    sc_bus();
    summarize();
  end
endmodule
bind lcs_sequencer lcs_sequencer_monitor #(.P_TICK_CYC(P_TICK_CYC), .P_TMO_CYC(P_TMO_CYC)) i_lcs_sequencer_monitor (
  .clk_sys(clk_sys), .arst_n(arst_n), .cfg_wr(cfg_wr), .read_busy(read_busy), .scl_in(scl_in), .sda_in(sda_in),
  .op_mode_ff(op_mode_ff), .integration_time_select_ff(integration_time_select_ff),
  .power_save_skip_ff(power_save_skip_ff), .result_low_byte_ff(result_low_byte_ff),
  .result_high_byte_ff(result_high_byte_ff), .result_new_ff(result_new_ff), .integrating_ff(integrating_ff),
  .bus_abort_ff(bus_abort_ff));
`default_nettype wire
